//--- window_watchdog_bench.sv
// Bench: host and watchdog ends joined by the link
`timescale 1ns/10ps
`default_nettype none
module window_watchdog_bench;
   localparam logic [7:0] AA = wwd_pkg::KEY_FIRST;
   localparam logic [7:0] K5 = wwd_pkg::KEY_SECOND;
   localparam logic [7:0] CF = wwd_pkg::CFG_ADDR;
   localparam logic [7:0] SV = wwd_pkg::SVC_ADDR;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        we = 1'b0;
   logic [31:0] adr = 32'h0;
   logic [31:0] dat = 32'h0;
   logic        nrm = 1'b1;
   logic        stp = 1'b0;
   logic        dbg = 1'b0;
   logic [7:0]  trim = 8'h00;
   logic        ce = 1'b1;
   logic [31:0] dat_o;
   logic        ack_o, rq, dis, wo;
   logic [7:0]  q;
   int          mismatches = 0;
   int          compares = 0;
   int          pulses = 0;
   int          p0, n;
   realtime     t0, tp;
   wwd_link_if  link ();
   // Short tick keeps every timeout to a few thousand cycles
   wwd_dev #(.TICK_CYCLES(4)) wwd_dev_i
   (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .link(link),
      .normal_mode_i(nrm), .stop_mode_i(stp),
      .debug_disable_voltage_i(dbg), .trim_i(trim),
      .wd_reset_req_o(rq), .guard_disabled_flag_o(dis),
      .service_window_open_flag_o(wo)
   );
   wwd_host wwd_host_i
   (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .link(link),
      .cyc_i(cyc), .stb_i(cyc), .we_i(we), .adr_i(adr),
      .dat_i(dat), .sel_i(4'h1), .dat_o(dat_o), .ack_o(ack_o)
   );
   wwd_link_assertions wwd_link_assertions_i
   (
      .clk_i(clk_i), .rst_i(rst_i), .req(link.req), .we(link.we),
      .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
      .ack(link.ack)
   );
   always #2 clk_i = ~clk_i;
   // Pulses can land inside a bus cycle, so they are logged here
   always @(posedge clk_i)
      if (rq === 1'b1)
      begin
         pulses++;
         tp = $realtime;
      end
   task results;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results
   task chk(input logic [7:0] s, input logic [7:0] e);
      compares++;
      if (s !== e)
      begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, s, e);
      end
   endtask : chk
   task hang;
      chk(8'h00, 8'h01);
      results;
   endtask : hang
   task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      cyc <= 1'b1;
      we <= w;
      adr <= {22'h0, a, 2'h0};
      dat <= {24'h0, d};
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end
      while (ack_o !== 1'b1 && k < 40);
      q = dat_o[7:0];
      cyc <= 1'b0;
      if (ack_o !== 1'b1)
         hang;
      @(posedge clk_i);
   endtask : wb
   task mark;
      t0 = $realtime;
      p0 = pulses;
   endtask : mark
   task rs;
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      mark;
   endtask : rs
   task wr(input int e, input int tol);
      int k;
      k = 0;
      while (pulses == p0 && k < e + tol + 4)
      begin
         @(posedge clk_i);
         k++;
      end
      if (pulses == p0)
         hang;
      n = int'((tp - t0) / 4.0);
      chk(n >= e - tol && n <= e + tol, 1'b1);
      @(posedge clk_i);
      p0 = pulses;
   endtask : wr
   task wop;
      n = 0;
      while (wo !== 1'b1 && n < 60)
      begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 60)
         hang;
   endtask : wop
   initial
   begin
      trim <= 8'h02;
      rs;
      @(posedge clk_i);
      chk(wo, 1'b1);
      chk(dis, 1'b0);
      wb(1'b1, CF, 8'h07);
      wb(1'b0, CF, 8'h00);
      chk(q, 8'h47);
      wb(1'b0, 8'h12, 8'h00);
      chk(q, 8'h00);
      wr(4 * (wwd_pkg::INIT_MS + 2), 3);
      chk(wo, 1'b1);
      trim <= 8'h00;
      rs;
      wb(1'b1, SV, K5);
      wr(4, 4);
      rs;
      ce <= 1'b0;
      repeat (1100) @(posedge clk_i);
      chk(pulses == p0, 1'b1);
      ce <= 1'b1;
      mark;
      wr(4 * wwd_pkg::INIT_MS, 3);
      $display("initial phase done");
      for (int c = 0; c < 8; c++)
      begin
         rs;
         wb(1'b1, CF, 8'(c));
         mark;
         wb(1'b1, SV, AA);
         chk(wo, 1'b0);
         wr(4 * ((c == 7) ? 1280 : 10 << c) + 2, 5);
      end
      $display("timeout codes done");
      rs;
      wb(1'b1, SV, AA);
      mark;
      wb(1'b1, SV, K5);
      wr(4, 4);
      rs;
      wb(1'b1, SV, AA);
      wop;
      chk(n > 12 && n < 23, 1'b1);
      wb(1'b1, SV, K5);
      wop;
      wb(1'b1, SV, AA);
      wop;
      chk(pulses == p0, 1'b1);
      mark;
      wb(1'b1, SV, AA);
      wr(4, 4);
      $display("window service done");
      rs;
      wb(1'b1, SV, AA);
      dbg <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk(dis, 1'b1);
      wb(1'b0, SV, 8'h00);
      chk(q, wwd_pkg::SVC_RESET);
      wb(1'b1, SV, AA);
      wb(1'b0, SV, 8'h00);
      chk(q, wwd_pkg::SVC_RESET);
      mark;
      repeat (1200) @(posedge clk_i);
      chk(pulses == p0, 1'b1);
      dbg <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(wo, 1'b1);
      chk(dis, 1'b0);
      mark;
      wb(1'b1, SV, K5);
      wr(4, 4);
      $display("debug disable done");
      rs;
      wb(1'b1, SV, AA);
      nrm <= 1'b0;
      stp <= 1'b1;
      wb(1'b0, CF, 8'h00);
      wb(1'b0, CF, 8'h00);
      chk(q[7], 1'b1);
      mark;
      repeat (300) @(posedge clk_i);
      chk(pulses == p0, 1'b1);
      wb(1'b0, SV, 8'h00);
      chk(q, wwd_pkg::SVC_RESET);
      nrm <= 1'b1;
      stp <= 1'b0;
      $display("low power done");
      results;
   end
endmodule : window_watchdog_bench
`default_nettype wire

//--- wwd_dev.sv
// Watchdog die end: initial timeout, window watchdog, register access
//
// Functional notes
// - Watchdog runs only in Normal mode
// - Timed from base clock, not link
// - Timeout selectable 10 ms to 1280 ms
// - Read during Stop sets disabled flag
// - Controller writes 0xAA first, then 0x55
// - Initial fixed timeout ignores config writes
// - Window-open flag set in initial phase
// - Initial timeout adjustable by trim value
// - First 0xAA resets counter, enters window
// - Initial expiry or wrong key resets
// - First half of window is closed
// - Controller services in second half, alternating
// - Window-open flag tracks open window
// - Window expiry or wrong key resets
// - Debug disable holds watchdog off
// - Disabled flag reports disabled state
// - Service register defaults when disabled
// - Re-enable restarts initial phase
// - Low power stops clock, defaults service
// - Codes double from 10 ms; 111 is 1280
// - Service writes ignored while disabled
//
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module wwd_dev #(
   parameter int TICK_CYCLES = wwd_pkg::TICK_CYCLES
)
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   wwd_link_if.dev         link,
   input  wire logic       normal_mode_i,
   input  wire logic       stop_mode_i,
   input  wire logic       debug_disable_voltage_i,
   input  wire logic [7:0] trim_i,
   output logic            wd_reset_req_o,
   output logic            guard_disabled_flag_o,
   output logic            service_window_open_flag_o
);
   typedef enum logic [1:0]
   {
      PH_INIT,
      PH_WINDOW,
      PH_RESET
   } wwd_phase_t;

   wwd_phase_t  phase_reg;
   logic [7:0]  svc_reg;
   logic [2:0]  tsel_reg;
   logic        off_reg;
   logic [11:0] ms_reg;
   logic [7:0]  rdata_reg;
   logic        ack_reg;
   logic        tick;
   logic        active;
   logic        svc_wr;
   logic        key_ok;
   logic        key_bad;
   logic [11:0] limit;
   logic        open_now;
   logic        div_clr;

   function automatic logic [11:0] tsel_ms(input logic [2:0] s);
      if (s == wwd_pkg::TSEL_LONGEST)
         return 12'(wwd_pkg::LONGEST_MS);
      else
         return 12'(wwd_pkg::BASE_MS << s);
   endfunction : tsel_ms

   // Keys alternate, so the last accepted key picks the next one
   function automatic logic [7:0] next_key(input logic [7:0] last);
      if (last == wwd_pkg::KEY_FIRST)
         return wwd_pkg::KEY_SECOND;
      else
         return wwd_pkg::KEY_FIRST;
   endfunction : next_key

   if (TICK_CYCLES < 2)
   begin : g_bad_tick
      $error("TICK_CYCLES must be at least 2");
   end

   assign active = normal_mode_i && !debug_disable_voltage_i;
   assign svc_wr = link.req && link.we && !ack_reg
                   && link.addr == wwd_pkg::SVC_ADDR;
   assign limit  = (phase_reg == PH_INIT)
                 ? 12'(wwd_pkg::INIT_MS) + {4'h0, trim_i}
                 : tsel_ms(tsel_reg);
   assign open_now = (phase_reg == PH_INIT)
                   || (ms_reg >= (limit >> 1));
   assign key_ok  = link.wdata == next_key(svc_reg) && open_now;
   assign key_bad = svc_wr && active && phase_reg != PH_RESET && !key_ok;
   // Divider restarts with each new timing period
   assign div_clr = ce_i && (!active || phase_reg == PH_RESET
                   || (svc_wr && key_ok));

   // Divider runs from base clock only, held cleared when inactive
   wwd_tick #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i && active),
      .clr_i  (div_clr),
      .tick_o (tick)
   );

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         phase_reg <= PH_INIT;
         ms_reg    <= 12'h0;
      end
      else if (ce_i)
      begin
         if (!active)
         begin
            phase_reg <= PH_INIT;
            ms_reg    <= 12'h0;
         end
         else if (phase_reg == PH_RESET)
         begin
            phase_reg <= PH_INIT;
            ms_reg    <= 12'h0;
         end
         else if (key_bad)
            phase_reg <= PH_RESET;
         else if (svc_wr && key_ok)
         begin
            phase_reg <= PH_WINDOW;
            ms_reg    <= 12'h0;
         end
         else if (tick)
         begin
            if (ms_reg + 12'h1 >= limit)
               phase_reg <= PH_RESET;
            else
               ms_reg <= ms_reg + 12'h1;
         end
      end
   end

   // Expected key toggles after each accepted service
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         svc_reg <= wwd_pkg::SVC_RESET;
      else if (ce_i)
      begin
         if (!active || phase_reg == PH_RESET)
            svc_reg <= wwd_pkg::SVC_RESET;
         else if (svc_wr && key_ok)
            svc_reg <= link.wdata;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         tsel_reg <= wwd_pkg::CFG_RESET[wwd_pkg::TSEL_MSB:0];
      else if (ce_i && link.req && link.we && !ack_reg
               && link.addr == wwd_pkg::CFG_ADDR)
         tsel_reg <= link.wdata[wwd_pkg::TSEL_MSB:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         off_reg <= 1'b0;
      else if (ce_i)
      begin
         if (debug_disable_voltage_i)
            off_reg <= 1'b1;
         else if (stop_mode_i && link.req && !link.we && !ack_reg)
            off_reg <= 1'b1;
         else if (active)
            off_reg <= 1'b0;
      end
   end

   // Single-cycle ack; service writes while disabled fall through
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_reg   <= 1'b0;
         rdata_reg <= 8'h00;
      end
      else if (ce_i)
      begin
         ack_reg <= link.req && !ack_reg;
         if (link.req && !link.we && !ack_reg)
         begin
            if (link.addr == wwd_pkg::CFG_ADDR)
               rdata_reg <= {off_reg, open_now, 3'h0, tsel_reg};
            else if (link.addr == wwd_pkg::SVC_ADDR)
               rdata_reg <= svc_reg;
            else
               rdata_reg <= 8'h00;
         end
      end
   end

   assign link.ack   = ack_reg;
   assign link.rdata = rdata_reg;
   assign wd_reset_req_o             = phase_reg == PH_RESET;
   assign guard_disabled_flag_o      = off_reg;
   assign service_window_open_flag_o = open_now && active;
endmodule : wwd_dev
`default_nettype wire

//--- wwd_host.sv
// Controller end: Wishbone slave driving link transfers
`timescale 1ns/10ps
`default_nettype none
module wwd_host
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   wwd_link_if.host         link,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [31:0] adr_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [3:0]  sel_i,
   output logic [31:0]      dat_o,
   output logic             ack_o
);
   // Register offsets sit at four times their value in byte space
   wwd_pkg::wwd_host_t st_reg;
   logic [7:0]         addr_reg;
   logic [7:0]         wdata_reg;
   logic [31:0]        dat_reg;
   logic               ack_reg;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_reg    <= wwd_pkg::WWD_IDLE;
         addr_reg  <= 8'h00;
         wdata_reg <= 8'h00;
         dat_reg   <= 32'h0;
         ack_reg   <= 1'b0;
      end
      else if (ce_i)
      begin
         ack_reg <= 1'b0;
         case (st_reg)
            wwd_pkg::WWD_IDLE:
               if (cyc_i && stb_i && !ack_reg)
               begin
                  addr_reg  <= adr_i[9:2];
                  wdata_reg <= sel_i[0] ? dat_i[7:0] : 8'h00;
                  st_reg    <= (we_i && sel_i[0]) ? wwd_pkg::WWD_WRITE
                             : we_i ? wwd_pkg::WWD_IDLE
                             : wwd_pkg::WWD_READ;
                  if (we_i && !sel_i[0])
                     ack_reg <= 1'b1;
               end
            default:
               if (link.ack)
               begin
                  dat_reg <= {24'h0, link.rdata};
                  ack_reg <= 1'b1;
                  st_reg  <= wwd_pkg::WWD_IDLE;
               end
         endcase
      end
   end

   assign link.req   = st_reg != wwd_pkg::WWD_IDLE;
   assign link.we    = st_reg == wwd_pkg::WWD_WRITE;
   assign link.addr  = addr_reg;
   assign link.wdata = wdata_reg;
   assign dat_o      = dat_reg;
   assign ack_o      = ack_reg;
endmodule : wwd_host
`default_nettype wire

//--- wwd_link_assertions.sv
// Link handshake checks between host and watchdog ends
`timescale 1ns/10ps
`default_nettype none
module wwd_link_assertions
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       req,
   input  wire logic       we,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic [7:0] rdata,
   input  wire logic       ack
);
   wire logic rd = ack && !we;
   wire logic hd = req && !ack;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_PULSE: assert property (ack |=> !ack)
      else $error("ack too long");
   AST_ACK_REQ: assert property (ack |-> req)
      else $error("ack without req");
   AST_ACK_NEXT: assert property ($rose(req) |=> ack)
      else $error("ack late");
   AST_REQ_HOLD: assert property (hd |=> req && $stable(addr))
      else $error("req not held");
   AST_WE_HOLD: assert property (hd |=> $stable(we))
      else $error("we changed");
   AST_WDATA_HOLD: assert property (hd && we |=> $stable(wdata))
      else $error("wdata changed");
   AST_REQ_DROP: assert property (ack |=> !req)
      else $error("req not dropped");
   AST_UNMAPPED: assert property
      (rd && addr > wwd_pkg::SVC_ADDR |-> rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_CFG_ZERO: assert property
      (rd && addr == wwd_pkg::CFG_ADDR |-> rdata[5:3] == 3'h0)
      else $error("reserved bits set");
   cover property (ack && we && addr == wwd_pkg::SVC_ADDR);
   cover property (rd && addr == wwd_pkg::CFG_ADDR);
   cover property (rd && addr > wwd_pkg::SVC_ADDR);
endmodule : wwd_link_assertions
`default_nettype wire

//--- wwd_link_if.sv
// Interface: register link between controller and watchdog die
`timescale 1ns/10ps
`default_nettype none
interface wwd_link_if;
   logic       req;
   logic       we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       ack;
   modport dev
   (
      input  req,
      input  we,
      input  addr,
      input  wdata,
      output rdata,
      output ack
   );
   modport host
   (
      output req,
      output we,
      output addr,
      output wdata,
      input  rdata,
      input  ack
   );
endinterface : wwd_link_if
`default_nettype wire

//--- wwd_pkg.sv
// Package: window watchdog register map, keys and timing constants
package wwd_pkg;
   localparam logic [7:0]  CFG_ADDR       = 8'h10;
   localparam logic [7:0]  SVC_ADDR       = 8'h11;
   localparam int          OFF_BIT        = 7;
   localparam int          WOPEN_BIT      = 6;
   localparam int          TSEL_MSB       = 2;
   localparam logic [7:0]  CFG_RESET      = 8'h00;
   localparam logic [7:0]  SVC_RESET      = 8'h55;
   localparam logic [7:0]  KEY_FIRST      = 8'hAA;
   localparam logic [7:0]  KEY_SECOND     = 8'h55;
   localparam logic [2:0]  TSEL_LONGEST   = 3'h7;
   localparam int          BASE_MS        = 10;
   localparam int          LONGEST_MS     = 1280;
   localparam int          INIT_MS        = 256;
   localparam int          TICK_NS        = 1000000;
   localparam int          CLK_NS         = 4;
   localparam int          TICK_CYCLES    = TICK_NS / CLK_NS;
   localparam logic [7:0]  TRIM_RESET     = 8'h00;
   typedef enum logic [1:0]
   {
      WWD_IDLE,
      WWD_READ,
      WWD_WRITE
   } wwd_host_t;
endpackage : wwd_pkg

//--- wwd_tick.sv
// Millisecond tick divider for the watchdog timers
`timescale 1ns/10ps
`default_nettype none
module wwd_tick #(
   parameter int CYCLES = wwd_pkg::TICK_CYCLES
)
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic       clr_i,
   output logic            tick_o
);
   if (CYCLES < 2)
   begin : g_bad_cycles
      $error("CYCLES must be at least 2");
   end
   logic [31:0] cnt_reg;
   always_ff @(posedge clk_i)
   begin
      if (rst_i || clr_i)
         cnt_reg <= 32'h0;
      else if (ce_i)
         cnt_reg <= (cnt_reg == 32'(CYCLES - 1)) ? 32'h0 : cnt_reg + 32'h1;
   end
   assign tick_o = ce_i && !clr_i && (cnt_reg == 32'(CYCLES - 1));
endmodule : wwd_tick
`default_nettype wire
